/* core/csm_params.svh */
// constants of the comparator status mirror: offsets, bit positions, reset values
// Function
// - Bit 15 is writable; one halts all comparators in idle, zero keeps them running.
// - Bits 11..8 are read-only event flags, channel four down to channel one.
// - Each event flag continuously mirrors bit nine of its channel control register.
// - Bits 3..0 are read-only output flags mirroring bit eight of channel control.
// - Output flag meaning follows the channel polarity-invert setting; passed through unchanged.
// - Bits 14..12 and 7..4 are unimplemented and always read zero.
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH

`define CSM_ADDR_W 12
`define CSM_OFS_STATUS 12'h000
`define CSM_OFS_INT_STATUS 12'h004
`define CSM_OFS_INT_MASK 12'h008

`define CSM_BIT_HALT_IDLE 15
`define CSM_POS_EVENT 8
`define CSM_POS_RESULT 0
`define CSM_CHAN_COUNT 4

`define CSM_RST_HALT_IDLE 1'h0
`define CSM_RST_FLAGS 4'h0
`define CSM_RST_RDATA 32'h0000_0000

`endif

/* core/csm_pkg.sv */
// types of the comparator status mirror
package csm_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} csm_apb_req_type;

	typedef struct packed {
		logic haltInIdle;
		logic [3:0] eventPrev;
		logic [3:0] intStatus;
		logic [3:0] intMask;
		logic [31:0] readData;
	} csm_state_type;
endpackage

/* core/csm_comparator_status_mirror.sv */
// apb register bank mirroring four comparator channels, with event interrupt
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`include "csm_params.svh"
module csm_comparator_status_mirror (
	// register bus
	input wire logic clk,
	input wire logic rst,
	input wire csm_pkg::csm_apb_req_type apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// channel mirror inputs
	input wire logic [3:0] channelEventBit,
	input wire logic [3:0] channelResultBit,
	// control and interrupt
	output logic comparatorsHaltInIdle,
	output logic irq
);
	// all registers of the block live in this one struct
	csm_pkg::csm_state_type state;
	csm_pkg::csm_state_type next_state;

	// bus request fields, unpacked for readability
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;

	// bus phase decode
	logic setupPhase;
	logic accessPhase;
	logic readSetup;
	logic writeAccess;
	logic readAccess;

	// address decode
	logic hitStatus;
	logic hitIntStatus;
	logic hitIntMask;
	logic mapped;
	logic unmappedAccess;

	// register strobes
	logic statusWriteEn;
	logic maskWriteEn;
	logic intStatusReadEn;

	// named views of the mirrored flags
	logic chan1EventFlag;
	logic chan2EventFlag;
	logic chan3EventFlag;
	logic chan4EventFlag;
	logic chan1OutputFlag;
	logic chan2OutputFlag;
	logic chan3OutputFlag;
	logic chan4OutputFlag;
	logic [15:0] statusWord;

	// per-channel event detection
	logic chan1Rise;
	logic chan2Rise;
	logic chan3Rise;
	logic chan4Rise;
	logic [3:0] eventRise;

	// interrupt bookkeeping
	logic [3:0] clearBits;
	logic [3:0] nextIntStatus;
	logic chan1Pending;
	logic chan2Pending;
	logic chan3Pending;
	logic chan4Pending;
	logic chan1IrqEnable;
	logic chan2IrqEnable;
	logic chan3IrqEnable;
	logic chan4IrqEnable;
	logic chan1Interrupt;
	logic chan2Interrupt;
	logic chan3Interrupt;
	logic chan4Interrupt;

	// register write and read paths
	logic nextHalt;
	logic [3:0] nextMask;
	logic [31:0] nextReadData;

	function automatic logic isStatusAddr(
		input logic [11:0] addr
	);
		isStatusAddr = (addr == `CSM_OFS_STATUS);
	endfunction

	function automatic logic isIntStatusAddr(
		input logic [11:0] addr
	);
		isIntStatusAddr = (addr == `CSM_OFS_INT_STATUS);
	endfunction

	function automatic logic isIntMaskAddr(
		input logic [11:0] addr
	);
		isIntMaskAddr = (addr == `CSM_OFS_INT_MASK);
	endfunction

	// anything outside the three words answers with an error and zero data
	function automatic logic isMapped(
		input logic [11:0] addr
	);
		isMapped = isStatusAddr(addr) || isIntStatusAddr(addr) || isIntMaskAddr(addr);
	endfunction

	function automatic logic [31:0] widenStatus(
		input logic [15:0] word
	);
		widenStatus = {16'h0000, word};
	endfunction

	function automatic logic [31:0] widenFlags(
		input logic [3:0] flags
	);
		widenFlags = {28'h000_0000, flags};
	endfunction

	// read multiplexer; unmapped addresses read zero
	function automatic logic [31:0] readSelect(
		input logic [11:0] addr,
		input logic [15:0] word,
		input logic [3:0] pending,
		input logic [3:0] enables
	);
		logic [31:0] data;
		data = `CSM_RST_RDATA;
		if (isStatusAddr(addr)) begin
			data = widenStatus(word);
		end else if (isIntStatusAddr(addr)) begin
			data = widenFlags(pending);
		end else if (isIntMaskAddr(addr)) begin
			data = widenFlags(enables);
		end
		readSelect = data;
	endfunction

	// sticky update: clear what was reported, then let new rises win
	function automatic logic [3:0] stickyUpdate(
		input logic [3:0] pending,
		input logic [3:0] clear,
		input logic [3:0] rise
	);
		logic [3:0] kept;
		kept = pending & ~clear;
		stickyUpdate = kept | rise;
	endfunction

	// bus request
	assign psel = apbReq.psel;
	assign penable = apbReq.penable;
	assign pwrite = apbReq.pwrite;
	assign paddr = apbReq.paddr;
	assign pwdata = apbReq.pwdata;

	// a transfer is one setup cycle, then access until pready
	assign setupPhase = psel && !penable;
	assign accessPhase = psel && penable;
	assign readSetup = setupPhase && !pwrite;
	assign writeAccess = accessPhase && pwrite;
	assign readAccess = accessPhase && !pwrite;

	// decode
	assign hitStatus = isStatusAddr(paddr);
	assign hitIntStatus = isIntStatusAddr(paddr);
	assign hitIntMask = isIntMaskAddr(paddr);
	assign mapped = isMapped(paddr);
	assign unmappedAccess = accessPhase && !mapped;

	// writes and the read-clear act only at the access edge
	assign statusWriteEn = writeAccess && hitStatus;
	assign maskWriteEn = writeAccess && hitIntMask;
	assign intStatusReadEn = readAccess && hitIntStatus;

	// channel one sits in bit zero of each input
	assign chan1EventFlag = channelEventBit[0];
	assign chan2EventFlag = channelEventBit[1];
	assign chan3EventFlag = channelEventBit[2];
	assign chan4EventFlag = channelEventBit[3];
	assign chan1OutputFlag = channelResultBit[0];
	assign chan2OutputFlag = channelResultBit[1];
	assign chan3OutputFlag = channelResultBit[2];
	assign chan4OutputFlag = channelResultBit[3];

	// unused positions stay zero by construction
	always_comb begin
		statusWord = 16'h0000;
		statusWord[`CSM_BIT_HALT_IDLE] = state.haltInIdle;
		statusWord[`CSM_POS_EVENT + 3] = chan4EventFlag;
		statusWord[`CSM_POS_EVENT + 2] = chan3EventFlag;
		statusWord[`CSM_POS_EVENT + 1] = chan2EventFlag;
		statusWord[`CSM_POS_EVENT] = chan1EventFlag;
		// polarity already applied inside each channel, so no inversion here
		statusWord[`CSM_POS_RESULT + 3] = chan4OutputFlag;
		statusWord[`CSM_POS_RESULT + 2] = chan3OutputFlag;
		statusWord[`CSM_POS_RESULT + 1] = chan2OutputFlag;
		statusWord[`CSM_POS_RESULT] = chan1OutputFlag;
	end

	// bits already high when reset ends count as one event each
	assign chan1Rise = chan1EventFlag && !state.eventPrev[0];
	assign chan2Rise = chan2EventFlag && !state.eventPrev[1];
	assign chan3Rise = chan3EventFlag && !state.eventPrev[2];
	assign chan4Rise = chan4EventFlag && !state.eventPrev[3];
	assign eventRise = {chan4Rise, chan3Rise, chan2Rise, chan1Rise};

	// only bits the reader was shown are cleared, so a rise at the setup edge survives
	always_comb begin
		clearBits = `CSM_RST_FLAGS;
		if (intStatusReadEn) begin
			clearBits = state.readData[3:0];
		end
	end

	// an event in the clearing cycle wins over the clear
	assign nextIntStatus = stickyUpdate(state.intStatus, clearBits, eventRise);

	// only the halt bit is writable; flag and unused positions ignore writes
	always_comb begin
		nextHalt = state.haltInIdle;
		if (statusWriteEn) begin
			nextHalt = pwdata[`CSM_BIT_HALT_IDLE];
		end
	end

	always_comb begin
		nextMask = state.intMask;
		if (maskWriteEn) begin
			nextMask = pwdata[3:0];
		end
	end

	// captured at setup so prdata comes from a flop and the bus needs no wait state
	// limitation: a flag that moves during the access phase shows at the next read
	always_comb begin
		nextReadData = state.readData;
		if (readSetup) begin
			nextReadData = readSelect(paddr, statusWord, state.intStatus, state.intMask);
		end else if (setupPhase) begin
			nextReadData = `CSM_RST_RDATA;
		end
	end

	// state register
	always_comb begin
		next_state = state;
		next_state.haltInIdle = nextHalt;
		next_state.eventPrev = channelEventBit;
		next_state.intStatus = nextIntStatus;
		next_state.intMask = nextMask;
		next_state.readData = nextReadData;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state.haltInIdle <= `CSM_RST_HALT_IDLE;
			state.eventPrev <= `CSM_RST_FLAGS;
			state.intStatus <= `CSM_RST_FLAGS;
			state.intMask <= `CSM_RST_FLAGS;
			state.readData <= `CSM_RST_RDATA;
		end else begin
			state <= next_state;
		end
	end

	// per-channel view of what is pending and what may interrupt
	assign chan1Pending = state.intStatus[0];
	assign chan2Pending = state.intStatus[1];
	assign chan3Pending = state.intStatus[2];
	assign chan4Pending = state.intStatus[3];
	assign chan1IrqEnable = state.intMask[0];
	assign chan2IrqEnable = state.intMask[1];
	assign chan3IrqEnable = state.intMask[2];
	assign chan4IrqEnable = state.intMask[3];

	assign chan1Interrupt = chan1Pending && chan1IrqEnable;
	assign chan2Interrupt = chan2Pending && chan2IrqEnable;
	assign chan3Interrupt = chan3Pending && chan3IrqEnable;
	assign chan4Interrupt = chan4Pending && chan4IrqEnable;

	// outputs
	assign prdata = state.readData;
	assign pready = 1'b1;

	// error only in the access phase, so a setup cycle never shows it
	assign pslverr = unmappedAccess;
	assign comparatorsHaltInIdle = state.haltInIdle;

	// level output: high until software reads the interrupt status or masks the channel
	assign irq = chan1Interrupt || chan2Interrupt || chan3Interrupt || chan4Interrupt;
endmodule

/* tb/csm_comparator_status_mirror_checker.sv */
// port assertions for the status mirror
`timescale 1ns/1ps
`include "csm_params.svh"
module csm_chk (
	input wire logic clk,
	input wire logic rst,
	input wire csm_pkg::csm_apb_req_type apbReq,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] channelEventBit,
	input wire logic [3:0] channelResultBit,
	input wire logic comparatorsHaltInIdle,
	input wire logic irq
);
	wire rd = apbReq.psel && !apbReq.penable && !apbReq.pwrite && !apbReq.paddr;
	wire wr = apbReq.psel && apbReq.penable && apbReq.pwrite && !apbReq.paddr;
	wire acc = apbReq.psel && apbReq.penable;
	wire offMap = apbReq.paddr != `CSM_OFS_STATUS && apbReq.paddr != `CSM_OFS_INT_STATUS
		&& apbReq.paddr != `CSM_OFS_INT_MASK;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence seq_rd_setup;
		rd;
	endsequence
	sequence seq_rd_access;
		acc && !apbReq.pwrite;
	endsequence
	chk_rd_hold: assert property (seq_rd_setup ##1 seq_rd_access |=> $stable(prdata)) else $error("prdata moved");
	chk_err_map: assert property (acc |-> pslverr == offMap) else $error("slave error wrong");
	chk_ready_on: assert property (pready) else $error("ready low");
	chk_irq_clr: assert property (disable iff (1'b0) rst |=> !irq) else $error("irq after reset");
	chk_halt_wr: assert property (wr |=> comparatorsHaltInIdle == $past(apbReq.pwdata[15])) else $error("halt");
	chk_halt_hold: assert property (!wr |=> $stable(comparatorsHaltInIdle)) else $error("hold");
	chk_evt_copy: assert property (rd |=> prdata[11:8] == $past(channelEventBit)) else $error("event");
	chk_res_copy: assert property (rd |=> prdata[3:0] == $past(channelResultBit)) else $error("result");
	chk_pad_zero: assert property (rd |=> !{prdata[31:16], prdata[14:12], prdata[7:4]}) else $error("pad");
	chk_rst_clr: assert property (disable iff (1'b0) rst |=> !comparatorsHaltInIdle) else $error("reset");
endmodule
bind csm_comparator_status_mirror csm_chk chk (.*);

/* tb/tb_comparator_status_mirror.sv */
// bench for the status mirror
`timescale 1ns/1ps
module tb_comparator_status_mirror;
	logic clk = 0, rst = 1, irq, rdy, err, halt;
	csm_pkg::csm_apb_req_type q = '0;
	logic [31:0] rd, w;
	logic [32:0] exq[$];
	logic [3:0] ev = 0, res = 0;
	int n_fail = 0, checked = 0;
	csm_comparator_status_mirror dut(.clk(clk), .rst(rst), .apbReq(q), .prdata(rd), .pready(rdy), .pslverr(err),
		.channelEventBit(ev), .channelResultBit(res), .comparatorsHaltInIdle(halt), .irq(irq));
	initial forever #20 clk = ~clk;
	task cmp(logic [32:0] s, e);
		checked++;
		n_fail += s !== e;
		if (s !== e) $display("wrong value %0t %h %h", $time, s, e);
	endtask
	task give_verdict(int late = 0);
		if (n_fail + late == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic bus(logic wr, logic [11:0] a, logic [31:0] d, e);
		int t = 0;
		q <= '{1'b1, 1'b0, wr, a, d};
		exq.push_back({a != 12'h000 && a != 12'h004 && a != 12'h008, (wr ? 32'h0000_0000 : e)});
		@(posedge clk) q.penable <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1 && t++ < 50);
		if (t > 49) give_verdict(1);
		q <= '0;
		@(posedge clk);
	endtask
	always @(posedge clk) if (q.psel && q.penable && rdy === 1'b1) cmp({err, (q.pwrite ? 32'h0000_0000 : rd)}, exq.pop_front());
	initial begin
		w = $urandom(33202);
		repeat (16) @(posedge clk);
		rst <= 0;
		ev <= 4'h5;
		@(posedge clk);
		bus(0, 12'h000, 32'h0000_0000, 32'h0000_0500);
		bus(1, 12'h008, 32'h0000_0004, 32'h0000_0000);
		cmp(irq, 1);
		bus(0, 12'h004, 32'h0000_0000, 32'h0000_0005);
		cmp(irq, 0);
		bus(1, 12'h004, 32'h0000_000F, 32'h0000_0000);
		bus(0, 12'h004, 32'h0000_0000, 32'h0000_0000);
		bus(0, 12'h0FC, 32'h0000_0000, 32'h0000_0000);
		repeat (9) begin
			w = $urandom;
			ev <= w[7:4];
			res <= w[3:0];
			bus(1, 12'h000, w, 32'h0000_0000);
			cmp(halt, w[15]);
			bus(0, 12'h000, 32'h0000_0000, {16'h0000, w[15], 3'h0, w[7:4], 4'h0, w[3:0]});
		end
		bus(1, 12'h000, 32'h0000_8000, 32'h0000_0000);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		cmp(halt, 0);
		bus(0, 12'h000, 32'h0000_0000, {16'h0000, 4'h0, w[7:4], 4'h0, w[3:0]});
		give_verdict(exq.size());
	end
endmodule
